// file: hw/fhc_regs.svh
/*
 * Constants for the floppy host command/status port: command codes,
 * register offsets, field indices and timing figures.
 * Assumes a single 200 MHz clock; included by the design modules.
 */
// Behaviour
// [RULE_01] Command bit 6 low puts the inverted status word on the input lines.
// [RULE_02] Status bit 6 always reads as logic 1.
// [RULE_03] Busy is 1 during an operation; Clear, Clear Errors, unload end it.
// [RULE_04] Status bits 2 and 1 carry the selected unit code.
// [RULE_05] Data error on Read or Read CRC sets a sticky error bit.
// [RULE_06] Bit 4 shows unit write protect, bit 5 shows drive not ready.
// [RULE_07] Read finding a deleted data mark sets a sticky bit 7.
// [RULE_08] Clear Error Flags resets the error and deleted-mark bits.
// [RULE_09] Clear aborts any operation, drops busy and pulses done.
// [RULE_10] Completion of an operation pulses the done output.
// [RULE_11] Seek reads ID, steps toward target, rereads until track matches.
// [RULE_12] Seek track zero steps out until track zero, ignoring target.
// [RULE_13] Load Unit/Sector and Load Track latch the data-output byte.
// [RULE_14] Read finds sector, fills read buffer, checks CRC, front at byte 0.
// [RULE_15] Examine shows buffer front; each shift advances one byte.
// [RULE_16] Read CRC checks the sector without touching the read buffer.
// [RULE_17] Host loads 128 write bytes; the write buffer recirculates.
// [RULE_18] Write emits 6 zeros, mark, data, two CRC bytes, one fill byte.
// [RULE_19] Write deleted is Write with the deleted mark instead.
// [RULE_20] Without interrupts the host polls status until busy clears.
// [RULE_21] Host issues seek track zero after power up and restart.
// [RULE_22] Host steps the buffers no faster than 500 kHz.
// [RULE_23] Command, data-output and status lines are all active low.
// [RULE_24] Command is held during strobe; decoded once per strobe.
// [RULE_25] Unknown command codes change nothing.
`ifndef FHC_REGS_SVH
`define FHC_REGS_SVH

`define FHC_CMD_STATUS 8'h00
`define FHC_CMD_READ 8'h03
`define FHC_CMD_WRITE 8'h05
`define FHC_CMD_RDCRC 8'h07
`define FHC_CMD_SEEK 8'h09
`define FHC_CMD_CLRERR 8'h0b
`define FHC_CMD_ZERO 8'h0d
`define FHC_CMD_WRDEL 8'h0f
`define FHC_CMD_LDTRK 8'h11
`define FHC_CMD_LDUS 8'h21
`define FHC_CMD_LDWB 8'h31
`define FHC_CMD_SHIFT 8'h41
`define FHC_CMD_CLEAR 8'h81
`define FHC_CMD_EXAM 8'h40

`define FHC_OFF_CTRL 12'h000
`define FHC_OFF_STAT 12'h004
`define FHC_CTRL_FILL_BIT 0

`define FHC_MARK_DATA 8'hfb
`define FHC_MARK_DEL 8'hf8
`define FHC_WR_MARK_IDX 8'd6
`define FHC_WR_DATA_IDX 8'd7
`define FHC_WR_CRC_IDX 8'd135
`define FHC_WR_LAST 8'd137
`define FHC_RD_LAST 8'd129
`define FHC_ID_TRK_IDX 3'd1
`define FHC_ID_SEC_IDX 3'd3
`define FHC_ID_LAST 3'd4

`define FHC_CRC_INIT 16'hffff
`define FHC_CRC_POLY 16'h1021

`define FHC_CLK_NS 5
`define FHC_BIT_NS 4000
`define FHC_BYTE_NS (8 * `FHC_BIT_NS)
`define FHC_STEP_NS 10000000
`define FHC_DONE_NS 1000

`endif

// file: hw/fhc_pkg.sv
/*
 * Types for the floppy host command/status port.
 * Assumes the constants header supplies all numeric values.
 */
package fhc_pkg;

	typedef enum logic [3:0] {
		st_idle = 4'h0,
		st_sk_id = 4'h1,
		st_step = 4'h2,
		st_z_chk = 4'h3,
		st_rd_id = 4'h4,
		st_rd_mark = 4'h5,
		st_rd_data = 4'h6,
		st_rd_end = 4'h7,
		st_wr_id = 4'h8,
		st_wr_field = 4'h9
	} fhc_state_t;

	// Positive-true status byte, bit 7 first
	typedef struct packed {
		logic status_in_line_seven;
		logic no_status;
		logic status_in_line_five;
		logic write_prot;
		logic status_in_line_three;
		logic unit_code_high;
		logic unit_code_low;
		logic status_in_line_zero;
	} fhc_status_t;

	// Byte stream from the data separator, one byte per valid
	typedef struct packed {
		logic valid;
		logic id_mark;
		logic data_mark;
		logic del_mark;
		logic [7:0] data;
	} fhc_dsk_in_t;

	typedef struct packed {
		logic wr_gate;
		logic valid;
		logic mark;
		logic [7:0] data;
	} fhc_dsk_out_t;

	typedef struct packed {
		logic head_load;
		logic step;
		logic step_out;
		logic [1:0] unit;
	} fhc_drv_ctl_t;

endpackage

// file: hw/fhc_crc16.sv
/*
 * Byte-wide CRC-16 (x^16+x^12+x^5+1) accumulator.
 * Assumes init and feed come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "fhc_regs.svh"

module fhc_crc16 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic init,
	input wire logic feed,
	input wire logic [7:0] data,
	output logic [15:0] crc
);

	logic [15:0] crc_ff;
	logic [15:0] base;

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--)
		begin
			if (r[15] ^ d[i])
				r = {r[14:0], 1'b0} ^ `FHC_CRC_POLY;
			else
				r = {r[14:0], 1'b0};
		end
		return r;
	endfunction

	assign base = init ? `FHC_CRC_INIT : crc_ff;

	// Init together with feed starts a fresh field on its first byte
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			crc_ff <= `FHC_CRC_INIT;
		else if (feed)
			crc_ff <= crc_byte(base, data);
		else if (init)
			crc_ff <= base;
	end

	assign crc = crc_ff;

endmodule // fhc_crc16

// file: hw/fhc_ctrl.sv
/*
 * Floppy controller host port: command decode, status, read and write
 * buffers, seek, read and write sequencing, APB config/status registers.
 * Assumes host pins are asynchronous and the disk byte stream and
 * drive status lines other than those synchronised share pclk.
 */
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "fhc_regs.svh"

module fhc_ctrl #(
	parameter int STEP_CYCLES =
		(`FHC_STEP_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS,
	parameter int BYTE_CYCLES =
		(`FHC_BYTE_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_strobe_n,
	input wire logic [7:0] cmd_n,
	input wire logic [7:0] host_data_out_lines_n,
	output logic [7:0] data_in_n,
	output logic done_n,
	input wire logic [3:0] wp_n,
	input wire logic [3:0] drive_ready_n,
	input wire logic track_zero_n,
	input fhc_pkg::fhc_dsk_in_t dsk_in,
	output fhc_pkg::fhc_dsk_out_t dsk_out,
	output fhc_pkg::fhc_drv_ctl_t drv_ctl
);

	localparam int DONE_CYCLES =
		(`FHC_DONE_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS;
	localparam int SYNC_W = 26;

	logic [SYNC_W-1:0] sync1_ff, sync2_ff;
	logic strobe_s, strobe_prev_ff, trk0_s;
	logic [7:0] cmd_s, dout_s;
	logic [3:0] wp_s, rdy_s;
	logic go;
	logic c_read, c_write, c_rdcrc, c_seek, c_cef, c_zero, c_wrdel;
	logic c_ltrk, c_lus, c_lwb, c_shift, c_clear, c_exam, c_stat;
	logic known, start, abort, drive_fail, id_done, mark_in, byte_tick;
	fhc_pkg::fhc_state_t state_ff;
	fhc_pkg::fhc_status_t stat;
	logic busy_ff, busy_prev_ff, crc_err_ff, del_ff, show_buf_ff;
	logic op_store_ff, op_del_ff, del_seen_ff, dir_ff, ret_zero_ff;
	logic fill_ones_ff;
	logic [1:0] unit_ff;
	logic [4:0] sector_ff;
	logic [7:0] target_ff, id_trk_ff, id_sec_ff, byte_cnt_ff, wr_data;
	logic [2:0] id_cnt_ff;
	logic [6:0] rptr_ff, wptr_ff;
	logic [31:0] tmr_ff, div_ff, done_cnt_ff;
	logic [7:0] rbuf [128];
	logic [7:0] wbuf [128];
	logic crc_init, crc_feed;
	logic [7:0] crc_data;
	logic [15:0] crc;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff, done_n_ff;
	logic [7:0] data_in_n_ff;
	fhc_pkg::fhc_dsk_out_t dsk_out_ff;
	fhc_pkg::fhc_drv_ctl_t drv_ctl_ff;
	logic apb_setup, apb_hit;

	// Host and drive pins are asynchronous; inactive level on reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_ff <= '1;
			sync2_ff <= '1;
		end
		else
		begin
			sync1_ff <= {cmd_strobe_n, cmd_n, host_data_out_lines_n, wp_n,
				drive_ready_n, track_zero_n};
			sync2_ff <= sync1_ff;
		end
	end

	// All synchronised host and drive pins are negative true
	assign {strobe_s, cmd_s, dout_s, wp_s, rdy_s, trk0_s} = ~sync2_ff; // [RULE_23]

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			strobe_prev_ff <= 1'b0;
		else
			strobe_prev_ff <= strobe_s;
	end

	// Strobe is level; act only on its leading edge
	assign go = strobe_s & ~strobe_prev_ff; // [RULE_24]
	assign c_stat = go && cmd_s == `FHC_CMD_STATUS;
	assign c_read = go && cmd_s == `FHC_CMD_READ;
	assign c_write = go && cmd_s == `FHC_CMD_WRITE;
	assign c_rdcrc = go && cmd_s == `FHC_CMD_RDCRC;
	assign c_seek = go && cmd_s == `FHC_CMD_SEEK;
	assign c_cef = go && cmd_s == `FHC_CMD_CLRERR;
	assign c_zero = go && cmd_s == `FHC_CMD_ZERO;
	assign c_wrdel = go && cmd_s == `FHC_CMD_WRDEL;
	assign c_ltrk = go && cmd_s == `FHC_CMD_LDTRK;
	assign c_lus = go && cmd_s == `FHC_CMD_LDUS;
	assign c_lwb = go && cmd_s == `FHC_CMD_LDWB;
	assign c_shift = go && cmd_s == `FHC_CMD_SHIFT;
	assign c_clear = go && cmd_s == `FHC_CMD_CLEAR;
	assign c_exam = go && cmd_s == `FHC_CMD_EXAM;
	assign known = c_stat | c_read | c_write | c_rdcrc | c_seek | c_cef |
		c_zero | c_wrdel | c_ltrk | c_lus | c_lwb | c_shift | c_clear |
		c_exam; // [RULE_25]

	assign drive_fail = ~rdy_s[unit_ff]; // [RULE_06]
	// Operation commands while busy are dropped, not queued
	assign start = ~busy_ff & (c_read | c_rdcrc | c_write | c_wrdel |
		c_seek | c_zero);
	// A drive going unready unloads the head and ends the operation
	assign abort = c_clear | c_cef | (busy_ff & drive_fail); // [RULE_03] [RULE_09]
	assign mark_in = dsk_in.valid & (dsk_in.data_mark | dsk_in.del_mark);
	assign id_done = dsk_in.valid & ~dsk_in.id_mark &
		(id_cnt_ff == `FHC_ID_LAST);
	assign byte_tick = (div_ff == '0);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_ff <= '0;
		else if (div_ff == 32'(BYTE_CYCLES - 1))
			div_ff <= '0;
		else
			div_ff <= div_ff + 32'd1;
	end

	// ID field: track, head, sector, length
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			id_cnt_ff <= '0;
			id_trk_ff <= '0;
			id_sec_ff <= '0;
		end
		else if (dsk_in.valid)
		begin
			if (dsk_in.id_mark)
				id_cnt_ff <= 3'd1;
			else if (id_cnt_ff != '0)
			begin
				if (id_cnt_ff == `FHC_ID_TRK_IDX)
					id_trk_ff <= dsk_in.data;
				if (id_cnt_ff == `FHC_ID_SEC_IDX)
					id_sec_ff <= dsk_in.data;
				id_cnt_ff <= (id_cnt_ff == `FHC_ID_LAST) ? 3'd0 :
					id_cnt_ff + 3'd1;
			end
		end
	end

	// Address latches; unit in bits 7:6, sector in bits 4:0
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			unit_ff <= '0;
			sector_ff <= '0;
			target_ff <= '0;
		end
		else
		begin
			if (c_lus)
			begin
				unit_ff <= dout_s[7:6]; // [RULE_13]
				sector_ff <= dout_s[4:0]; // [RULE_13]
			end
			if (c_ltrk)
				target_ff <= dout_s; // [RULE_13]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= fhc_pkg::st_idle;
			busy_ff <= 1'b0;
			tmr_ff <= '0;
			byte_cnt_ff <= '0;
			dir_ff <= 1'b0;
			ret_zero_ff <= 1'b0;
			op_store_ff <= 1'b0;
			op_del_ff <= 1'b0;
			del_seen_ff <= 1'b0;
		end
		else if (abort)
		begin
			state_ff <= fhc_pkg::st_idle;
			busy_ff <= 1'b0; // [RULE_03] [RULE_09]
		end
		else
		begin
			unique case (state_ff)
				fhc_pkg::st_idle:
					if (start)
					begin
						busy_ff <= 1'b1; // [RULE_03]
						op_store_ff <= c_read;
						op_del_ff <= c_wrdel; // [RULE_19]
						tmr_ff <= '0;
						if (c_seek)
							state_ff <= fhc_pkg::st_sk_id;
						else if (c_zero)
							state_ff <= fhc_pkg::st_z_chk;
						else if (c_read | c_rdcrc)
							state_ff <= fhc_pkg::st_rd_id;
						else
							state_ff <= fhc_pkg::st_wr_id;
					end
				fhc_pkg::st_sk_id:
					if (id_done)
					begin
						if (id_trk_ff == target_ff) // [RULE_11]
						begin
							state_ff <= fhc_pkg::st_idle;
							busy_ff <= 1'b0;
						end
						else
						begin
							dir_ff <= id_trk_ff > target_ff; // [RULE_11]
							ret_zero_ff <= 1'b0;
							state_ff <= fhc_pkg::st_step;
						end
					end
				fhc_pkg::st_z_chk:
					if (trk0_s) // [RULE_12]
					begin
						state_ff <= fhc_pkg::st_idle;
						busy_ff <= 1'b0;
					end
					else
					begin
						dir_ff <= 1'b1; // [RULE_12]
						ret_zero_ff <= 1'b1;
						state_ff <= fhc_pkg::st_step;
					end
				fhc_pkg::st_step:
					if (tmr_ff == 32'(STEP_CYCLES - 1))
					begin
						tmr_ff <= '0;
						state_ff <= ret_zero_ff ? fhc_pkg::st_z_chk :
							fhc_pkg::st_sk_id; // [RULE_11]
					end
					else
						tmr_ff <= tmr_ff + 32'd1;
				fhc_pkg::st_rd_id:
					if (id_done && id_sec_ff == {3'd0, sector_ff}) // [RULE_14]
						state_ff <= fhc_pkg::st_rd_mark;
				fhc_pkg::st_rd_mark:
					if (mark_in)
					begin
						del_seen_ff <= dsk_in.del_mark; // [RULE_07]
						byte_cnt_ff <= '0;
						state_ff <= fhc_pkg::st_rd_data;
					end
				fhc_pkg::st_rd_data:
					if (dsk_in.valid)
					begin
						byte_cnt_ff <= byte_cnt_ff + 8'd1;
						if (byte_cnt_ff == `FHC_RD_LAST)
							state_ff <= fhc_pkg::st_rd_end;
					end
				fhc_pkg::st_rd_end:
				begin
					state_ff <= fhc_pkg::st_idle;
					busy_ff <= 1'b0;
				end
				fhc_pkg::st_wr_id:
					if (id_done && id_sec_ff == {3'd0, sector_ff})
					begin
						byte_cnt_ff <= '0;
						state_ff <= fhc_pkg::st_wr_field;
					end
				fhc_pkg::st_wr_field:
					if (byte_tick)
					begin
						if (byte_cnt_ff == `FHC_WR_LAST) // [RULE_18]
						begin
							state_ff <= fhc_pkg::st_idle;
							busy_ff <= 1'b0;
						end
						else
							byte_cnt_ff <= byte_cnt_ff + 8'd1;
					end
				default:
					state_ff <= fhc_pkg::st_idle;
			endcase
		end
	end

	// Sticky flags; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_err_ff <= 1'b0;
			del_ff <= 1'b0;
		end
		else
		begin
			if (state_ff == fhc_pkg::st_rd_end && crc != 16'h0000)
				crc_err_ff <= 1'b1; // [RULE_05] [RULE_14] [RULE_16]
			else if (c_cef)
				crc_err_ff <= 1'b0; // [RULE_08]
			if (state_ff == fhc_pkg::st_rd_end && op_store_ff && del_seen_ff)
				del_ff <= 1'b1; // [RULE_07]
			else if (c_cef)
				del_ff <= 1'b0; // [RULE_08]
		end
	end

	// Read CRC runs the same path with the store disabled
	always_ff @(posedge pclk)
	begin
		if (state_ff == fhc_pkg::st_rd_data && dsk_in.valid && op_store_ff &&
			!byte_cnt_ff[7])
			rbuf[byte_cnt_ff[6:0]] <= dsk_in.data; // [RULE_14] [RULE_16]
	end

	always_ff @(posedge pclk)
	begin
		if (c_lwb)
			wbuf[wptr_ff] <= dout_s; // [RULE_17]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rptr_ff <= '0;
			wptr_ff <= '0;
		end
		else
		begin
			if (state_ff == fhc_pkg::st_rd_end && op_store_ff)
				rptr_ff <= '0; // [RULE_14]
			else if (c_shift)
				rptr_ff <= rptr_ff + 7'd1; // [RULE_15]
			// Pointer wraps so a rewrite needs no reload
			if (c_lwb)
				wptr_ff <= wptr_ff + 7'd1; // [RULE_17]
		end
	end

	// Write field byte for the current position
	always_comb
	begin
		if (byte_cnt_ff < `FHC_WR_MARK_IDX)
			wr_data = 8'h00; // [RULE_18]
		else if (byte_cnt_ff == `FHC_WR_MARK_IDX)
			wr_data = op_del_ff ? `FHC_MARK_DEL : `FHC_MARK_DATA; // [RULE_19]
		else if (byte_cnt_ff < `FHC_WR_CRC_IDX)
			wr_data = wbuf[7'(byte_cnt_ff - `FHC_WR_DATA_IDX)]; // [RULE_18]
		else if (byte_cnt_ff == `FHC_WR_CRC_IDX)
			wr_data = crc[15:8];
		else if (byte_cnt_ff == `FHC_WR_CRC_IDX + 8'd1)
			wr_data = crc[7:0];
		else
			wr_data = fill_ones_ff ? 8'hff : 8'h00; // [RULE_18]
	end

	// The mark is part of the checked field on both read and write
	always_comb
	begin
		crc_init = 1'b0;
		crc_feed = 1'b0;
		crc_data = dsk_in.data;
		if (state_ff == fhc_pkg::st_rd_mark)
		begin
			crc_init = 1'b1;
			crc_feed = mark_in;
		end
		else if (state_ff == fhc_pkg::st_rd_data)
			crc_feed = dsk_in.valid;
		else if (state_ff == fhc_pkg::st_wr_field)
		begin
			crc_data = wr_data;
			crc_init = byte_cnt_ff == `FHC_WR_MARK_IDX;
			crc_feed = byte_tick && byte_cnt_ff >= `FHC_WR_MARK_IDX &&
				byte_cnt_ff < `FHC_WR_CRC_IDX;
		end
	end

	fhc_crc16 u_crc (
		.pclk(pclk),
		.presetn(presetn),
		.init(crc_init),
		.feed(crc_feed),
		.data(crc_data),
		.crc(crc)
	);

	always_comb
	begin
		stat = '0;
		stat.status_in_line_zero = busy_ff; // [RULE_03]
		stat.unit_code_low = unit_ff[0]; // [RULE_04]
		stat.unit_code_high = unit_ff[1]; // [RULE_04]
		stat.status_in_line_three = crc_err_ff; // [RULE_05]
		stat.write_prot = wp_s[unit_ff]; // [RULE_06]
		stat.status_in_line_five = drive_fail; // [RULE_06]
		stat.no_status = 1'b1; // [RULE_02]
		stat.status_in_line_seven = del_ff; // [RULE_07]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			show_buf_ff <= 1'b0;
			data_in_n_ff <= '1;
		end
		else
		begin
			if (known)
				show_buf_ff <= cmd_s[6]; // [RULE_01]
			data_in_n_ff <= show_buf_ff ? ~rbuf[rptr_ff] :
				~stat; // [RULE_01] [RULE_15] [RULE_23]
		end
	end

	// Done pulse long enough for an edge-triggered host input
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy_prev_ff <= 1'b0;
			done_cnt_ff <= '0;
			done_n_ff <= 1'b1;
		end
		else
		begin
			busy_prev_ff <= busy_ff;
			if (c_clear || (busy_prev_ff && !busy_ff)) // [RULE_09] [RULE_10]
				done_cnt_ff <= 32'(DONE_CYCLES);
			else if (done_cnt_ff != '0)
				done_cnt_ff <= done_cnt_ff - 32'd1;
			done_n_ff <= (done_cnt_ff == '0);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dsk_out_ff <= '0;
			drv_ctl_ff <= '0;
		end
		else
		begin
			dsk_out_ff.wr_gate <= state_ff == fhc_pkg::st_wr_field;
			dsk_out_ff.valid <= state_ff == fhc_pkg::st_wr_field && byte_tick;
			dsk_out_ff.mark <= byte_cnt_ff == `FHC_WR_MARK_IDX;
			dsk_out_ff.data <= wr_data;
			drv_ctl_ff.head_load <= busy_ff;
			drv_ctl_ff.step <= state_ff == fhc_pkg::st_step &&
				tmr_ff == '0; // [RULE_11] [RULE_12]
			drv_ctl_ff.step_out <= dir_ff;
			drv_ctl_ff.unit <= unit_ff;
		end
	end

	// APB: setup cycle registers the answer, access cycle has pready
	assign apb_setup = psel & ~penable;
	assign apb_hit = (paddr == `FHC_OFF_CTRL) || (paddr == `FHC_OFF_STAT);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
			fill_ones_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= apb_setup;
			pslverr_ff <= apb_setup & ~apb_hit;
			if (apb_setup && !pwrite && paddr == `FHC_OFF_CTRL)
				prdata_ff <= {31'd0, fill_ones_ff};
			else if (apb_setup && !pwrite && paddr == `FHC_OFF_STAT)
				prdata_ff <= {4'h0, state_ff, id_trk_ff, target_ff, stat};
			else
				prdata_ff <= '0;
			if (psel && penable && pready_ff && pwrite &&
				paddr == `FHC_OFF_CTRL)
				fill_ones_ff <= pwdata[`FHC_CTRL_FILL_BIT];
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign data_in_n = data_in_n_ff;
	assign done_n = done_n_ff;
	assign dsk_out = dsk_out_ff;
	assign drv_ctl = drv_ctl_ff;

endmodule // fhc_ctrl

// file: tb/fhc_ctrl_assertions.sv
/*
 * Checker for fhc_ctrl: APB timing, done pulse, stepping, write field.
 * Assumes it is bound to fhc_ctrl and sees only its ports.
 */
`timescale 1ns/1ps
module fhc_ctrl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic done_n,
	input fhc_pkg::fhc_dsk_out_t dsk_out,
	input fhc_pkg::fhc_drv_ctl_t drv_ctl
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	chk_pready_setup: assert property (s_setup |=> pready)
		else $error("no pready after setup");
	chk_unmapped_err: assert property (s_access
		and (paddr != 12'h000 && paddr != 12'h004) |-> pslverr)
		else $error("unmapped access without pslverr");
	chk_stat_bit_six: assert property (
		s_access and (!pwrite && paddr == 12'h004) |-> prdata[6])
		else $error("status bit 6 low");
	chk_done_pulse: assert property (
		$fell(done_n) |=> !done_n[*8])
		else $error("done pulse too short");
	chk_step_loaded: assert property (
		drv_ctl.step |-> drv_ctl.head_load)
		else $error("step without head load");
	chk_step_space: assert property (
		drv_ctl.step |=> !drv_ctl.step[*8])
		else $error("steps too close");
	chk_mark_value: assert property (
		dsk_out.valid && dsk_out.mark
		|-> dsk_out.data inside {8'hfb, 8'hf8})
		else $error("bad mark byte");
	chk_gate_busy: assert property (
		dsk_out.wr_gate |-> drv_ctl.head_load)
		else $error("write gate while idle");
endmodule // fhc_ctrl_chk

bind fhc_ctrl fhc_ctrl_chk fhc_ctrl_chk_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .done_n(done_n), .dsk_out(dsk_out),
	.drv_ctl(drv_ctl)
);

// file: tb/fhc_disk_model.sv
/*
 * Drive model: head position, track zero sensor, one sector per turn.
 * Assumes drv_ctl comes from fhc_ctrl on the same clock.
 */
`timescale 1ns/1ps
`include "fhc_regs.svh"
module fhc_disk_model (
	input wire logic pclk,
	input fhc_pkg::fhc_drv_ctl_t drv_ctl,
	output fhc_pkg::fhc_dsk_in_t dsk_in,
	output logic track_zero_n
);
	int trk = 3;
	logic [7:0] pat = 8'h5a;
	logic del = 1'h1;
	always @(posedge pclk)
		if (drv_ctl.step)
			trk <= drv_ctl.step_out ? (trk > 0 ? trk - 1 : 0) : trk + 1;
	assign track_zero_n = (trk != 0);
	// Idle data shows the inverse, never a stale byte
	task automatic put(input logic [2:0] f, input logic [7:0] d);
		dsk_in <= {1'h1, f, d};
		@(posedge pclk);
		dsk_in <= {4'h0, ~d};
		repeat (3) @(posedge pclk);
	endtask
	// Logical track is one above physical; CRC bytes zero, so always bad
	initial
	begin
		dsk_in = '0;
		forever
		begin
			@(posedge pclk);
			if (drv_ctl.head_load)
			begin
				put(3'h4, 8'hfe);
				put(3'h0, 8'(trk + 1));
				put(3'h0, 8'h00);
				put(3'h0, 8'h01);
				for (int i = 0; i < 3; i++)
					put(3'h0, 8'h00);
				repeat (8) @(posedge pclk);
				put(del ? 3'h1 : 3'h2, del ? `FHC_MARK_DEL : `FHC_MARK_DATA);
				for (int i = 0; i < 130; i++)
					put(3'h0, i < 128 ? 8'(i) ^ pat : 8'h00);
			end
		end
	end
endmodule // fhc_disk_model

// file: tb/floppy_host_command_status_port_test.sv
/*
 * Self-checking bench for fhc_ctrl: host port, APB, seek, read, write.
 * Assumes fhc_disk_model plays the drive and the checker is bound.
 */
`timescale 1ns/1ps
`include "fhc_regs.svh"
module floppy_host_command_status_port_test;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, done_n, track_zero_n, er;
	logic cmd_strobe_n = 1'h1;
	logic [7:0] cmd_n = 8'hff, host_data_out_lines_n = 8'hff, data_in_n;
	logic [3:0] wp_n = 4'hf, drive_ready_n = 4'h0;
	fhc_pkg::fhc_dsk_in_t dsk_in;
	fhc_pkg::fhc_dsk_out_t dsk_out;
	fhc_pkg::fhc_drv_ctl_t drv_ctl;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	logic [7:0] wq[$];
	always #2.5 pclk = ~pclk;
	fhc_ctrl #(.STEP_CYCLES(20), .BYTE_CYCLES(8)) fhc_ctrl_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd_strobe_n(cmd_strobe_n),
		.cmd_n(cmd_n), .host_data_out_lines_n(host_data_out_lines_n),
		.data_in_n(data_in_n), .done_n(done_n), .wp_n(wp_n),
		.drive_ready_n(drive_ready_n), .track_zero_n(track_zero_n),
		.dsk_in(dsk_in), .dsk_out(dsk_out), .drv_ctl(drv_ctl));
	fhc_disk_model fhc_disk_model_inst (.pclk(pclk), .drv_ctl(drv_ctl),
		.dsk_in(dsk_in), .track_zero_n(track_zero_n));
	always @(posedge pclk)
		if (dsk_out.valid === 1'h1)
			wq.push_back(dsk_out.data);
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 125000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic cmp8(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmp1(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s exp %h got %h", nm, e, g);
		end
	endtask
	// Code and data held for the whole low strobe
	task automatic cmd(input logic [7:0] c, input logic [7:0] d, int gap);
		@(posedge pclk);
		cmd_n <= ~c;
		host_data_out_lines_n <= ~d;
		cmd_strobe_n <= 1'h0;
		repeat (4) @(posedge pclk);
		cmd_strobe_n <= 1'h1;
		repeat (gap) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the bench timeout ends a stuck wait
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		while (done_n !== 1'h0 && n < 20000)
		begin
			@(posedge pclk);
			n++;
		end
		cmp1("done", 1'h1, n < 20000);
		repeat (210) @(posedge pclk);
	endtask
	task automatic t_idle;
		cmp8("status", 8'hbf, data_in_n);
		apb(1'h0, `FHC_OFF_STAT, 32'h0);
		cmp8("stat reg", 8'h40, rd[7:0]);
		apb(1'h0, `FHC_OFF_CTRL, 32'h0);
		cmp8("ctrl reg", 8'h00, rd[7:0]);
		apb(1'h1, 12'h008, 32'h1);
		cmp1("pslverr", 1'h1, er);
	endtask
	task automatic t_units;
		logic [7:0] e;
		wp_n <= 4'h7;
		drive_ready_n <= 4'h4;
		for (int u = 0; u < 4; u++)
		begin
			e = {2'h1, u == 2, u == 3, 1'h0, u[1:0], 1'h0};
			cmd(`FHC_CMD_LDUS, {u[1:0], 6'h01}, 8);
			cmd(`FHC_CMD_STATUS, 8'h00, 8);
			cmp8("status", ~e, data_in_n);
			cmp8("drv unit", 8'(u), {6'h00, drv_ctl.unit});
		end
		wp_n <= 4'hf;
		drive_ready_n <= 4'h0;
		cmd(`FHC_CMD_LDUS, 8'h01, 8);
		cmd(`FHC_CMD_STATUS, 8'h00, 8);
		cmd(8'h53, 8'h00, 8);
		cmp8("status", 8'hbf, data_in_n);
	endtask
	task automatic t_seek;
		cmd(`FHC_CMD_ZERO, 8'h00, 8);
		wait_done();
		cmp8("track", 8'h00, 8'(fhc_disk_model_inst.trk));
		cmd(`FHC_CMD_LDTRK, 8'h09, 8);
		cmd(`FHC_CMD_SEEK, 8'h00, 8);
		cmd(`FHC_CMD_CLEAR, 8'h00, 8);
		wait_done();
		cmp8("status", 8'hbf, data_in_n);
		cmd(`FHC_CMD_LDTRK, 8'h05, 8);
		cmd(`FHC_CMD_SEEK, 8'h00, 8);
		wait_done();
		cmp8("track", 8'h04, 8'(fhc_disk_model_inst.trk));
	endtask
	task automatic t_read;
		cmd(`FHC_CMD_READ, 8'h00, 8);
		cmp1("busy", 1'h0, data_in_n[0]);
		wait_done();
		cmp8("status", 8'h37, data_in_n);
		cmd(`FHC_CMD_EXAM, 8'h00, 8);
		cmp8("front", 8'ha5, data_in_n);
		for (int i = 1; i < 128; i++)
		begin
			cmd(`FHC_CMD_SHIFT, 8'h00, 395);
			cmp8("shift", ~(8'(i) ^ 8'h5a), data_in_n);
		end
		cmd(`FHC_CMD_CLRERR, 8'h00, 210);
		cmp8("status", 8'hbf, data_in_n);
		fhc_disk_model_inst.pat = 8'h33;
		fhc_disk_model_inst.del = 1'h0;
		cmd(`FHC_CMD_RDCRC, 8'h00, 8);
		wait_done();
		cmp8("status", 8'hb7, data_in_n);
		// Front stays at the last shifted byte
		cmd(`FHC_CMD_EXAM, 8'h00, 8);
		cmp8("front", ~(8'd127 ^ 8'h5a), data_in_n);
		cmd(`FHC_CMD_CLRERR, 8'h00, 210);
	endtask
	task automatic t_write;
		for (int i = 0; i < 128; i++)
			cmd(`FHC_CMD_LDWB, 8'(i) ^ 8'hc3, 395);
		for (int k = 0; k < 2; k++)
		begin
			if (k == 1)
				apb(1'h1, `FHC_OFF_CTRL, 32'h1);
			wq.delete();
			cmd(k ? `FHC_CMD_WRDEL : `FHC_CMD_WRITE, 8'h00, 8);
			wait_done();
			cmp8("count", 8'h8a, 8'(wq.size()));
			for (int i = 0; i < 6; i++)
				cmp8("zero", 8'h00, wq[i]);
			cmp8("mark", k ? 8'hf8 : 8'hfb, wq[6]);
			for (int i = 0; i < 128; i++)
				cmp8("data", 8'(i) ^ 8'hc3, wq[7 + i]);
			cmp8("fill", k ? 8'hff : 8'h00, wq[137]);
		end
	endtask
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		repeat (8) @(posedge pclk);
		t_idle();
		t_units();
		t_seek();
		t_read();
		t_write();
		print_verdict();
	end
endmodule // floppy_host_command_status_port_test
